// >>> supervisor_pkg.sv
// Shared constants, register map and state types of the soft-start supervisor
package supervisor_pkg;
  // Ramp
  localparam int RAMP_W = 12;
  localparam int RAMP_SHIFT = 11;
  localparam logic [11:0] RAMP_FULL = 12'h800;
  // Reference scaling in millivolts, voltage code to final reference
  localparam int MV_W = 12;
  localparam logic [11:0] REF_BASE_MV = 12'h320;
  localparam logic [11:0] REF_STEP_MV = 12'h019;
  localparam logic [11:0] UV_ENABLE_MV = 12'h258;
  // Under-voltage must stand this many samples before it trips
  localparam logic [1:0] UV_HOLD_CYCLES = 2'h2;
  localparam int PHASES = 2;
  localparam int CODE_W = 5;
  // Register offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_RAMP = 8'h04;
  localparam logic [7:0] OFS_UV_LEVEL = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  // Status and ramp register fields
  localparam int ST_RAMP_DONE_BIT = 0;
  localparam int ST_FAULT_BIT = 1;
  localparam int ST_SUPPLY_OK_BIT = 2;
  localparam int ST_IRQ_BIT = 3;
  localparam int ST_STATE_LSB = 4;
  localparam int RAMP_MV_LSB = 16;
  // Interrupt bits
  localparam int IRQ_W = 5;
  localparam int IRQ_UV = 0;
  localparam int IRQ_OV = 1;
  localparam int IRQ_OCP = 2;
  localparam int IRQ_RAMP_DONE = 3;
  localparam int IRQ_SUPPLY = 4;
  localparam logic [4:0] IRQ_MASK_RESET = 5'h00;
  typedef enum logic [2:0] {
    ST_OFF,
    ST_RAMP,
    ST_RUN,
    ST_UV_LATCH,
    ST_OV_LATCH
  } state_t;
endpackage : supervisor_pkg

// >>> ramp_if.sv
// Handshake between the sequencer and its soft-start counter
`timescale 1ns/10ps
interface ramp_if;
  logic clear;
  logic advance;
  logic [11:0] count;
  logic done;
  modport ctl (output clear, output advance, input count, input done);
  modport cnt (input clear, input advance, output count, output done);
endinterface : ramp_if

// >>> soft_ramp_counter.sv
// Soft-start step counter
`timescale 1ns/10ps
module soft_ramp_counter
  import supervisor_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Sequencer side
  ramp_if.cnt rp
);
  logic [RAMP_W-1:0] count_q;

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      count_q <= 12'h000;
    else if (rp.clear)
      count_q <= 12'h000;
    else if (rp.advance && count_q != RAMP_FULL)
      count_q <= count_q + 12'h001;
  end

  assign rp.count = count_q;
  assign rp.done = (count_q == RAMP_FULL);
endmodule : soft_ramp_counter

// >>> phase_gate_driver.sv
// Per-phase gate enables with overcurrent cycle skipping and crowbar
`timescale 1ns/10ps
module phase_gate_driver
  import supervisor_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Control
  input wire logic run_i,
  input wire logic crowbar_i,
  input wire logic [PHASES-1:0] over_limit_i,
  input wire logic [PHASES-1:0] pwm_i,
  // Gate enables
  output logic [PHASES-1:0] high_o,
  output logic [PHASES-1:0] low_o,
  output logic ocp_rise_o
);
  logic [PHASES-1:0] high_q;
  logic [PHASES-1:0] low_q;
  logic [PHASES-1:0] ocp_q;
  logic [PHASES-1:0] rise;

  for (genvar p = 0; p < PHASES; p++)
  begin : g_phase
    logic high_d;
    logic low_d;
    // High side only without overcurrent, crowbar or low side
    assign high_d = run_i && !crowbar_i && !over_limit_i[p] && pwm_i[p];
    assign low_d = crowbar_i || (run_i && (over_limit_i[p] || !pwm_i[p]));
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
      begin
        high_q[p] <= 1'b0;
        low_q[p] <= 1'b0;
        ocp_q[p] <= 1'b0;
      end
      else
      begin
        high_q[p] <= high_d && !low_d;
        low_q[p] <= low_d;
        ocp_q[p] <= run_i && over_limit_i[p];
      end
    end
    assign rise[p] = run_i && over_limit_i[p] && !ocp_q[p];
  end

  assign high_o = high_q;
  assign low_o = low_q;
  assign ocp_rise_o = |rise;
endmodule : phase_gate_driver

// >>> softstart_fault_supervisor.sv
// Soft-start sequencer, fault latches and APB registers of the supervisor
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/10ps
module softstart_fault_supervisor
  import supervisor_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Supply and inhibit comparators
  input wire logic main_supply_ok_i,
  input wire logic driver_supply_ok_i,
  input wire logic inhibit_input_i,
  // Output voltage comparators and programming
  input wire logic [CODE_W-1:0] voltage_code_i,
  input wire logic sensed_below_uv_i,
  input wire logic sensed_above_ov_i,
  input wire logic sensed_in_window_i,
  // Phase current and loop demand
  input wire logic [PHASES-1:0] phase_over_limit_i,
  input wire logic [PHASES-1:0] pwm_demand_i,
  // Loop references
  output logic [MV_W-1:0] loop_ref_mv_o,
  output logic [MV_W-1:0] ov_ref_mv_o,
  // Gate drives and indicators
  output logic [PHASES-1:0] high_side_en_o,
  output logic [PHASES-1:0] low_side_en_o,
  output logic fault_indicator_o,
  output logic supply_ok_output_o,
  output logic irq_o
);
  state_t state_q;
  state_t state_d;
  logic supplies_ok;
  logic prot_on;
  logic ov_trip;
  logic uv_trip;
  logic uv_armed;
  logic [1:0] uv_cnt_q;
  logic [MV_W-1:0] final_mv;
  logic [23:0] ramp_prod;
  logic [MV_W-1:0] ramp_mv;
  logic [MV_W-1:0] loop_ref_q;
  logic [MV_W-1:0] ov_ref_q;
  logic [MV_W-1:0] uv_level_q;
  logic fault_q;
  logic supply_ok_q;
  logic run_gate;
  logic crowbar;
  logic ocp_rise;
  logic [IRQ_W-1:0] irq_event;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_clear;
  logic [31:0] prdata_q;
  logic [31:0] rd_value;
  logic rd_hit;
  logic setup_ph;
  logic access_ph;
  logic wr_en;

  ramp_if rp ();

  soft_ramp_counter u_ramp (
    .clk_sys_i (clk_sys_i),
    .rst_n_i (rst_n_i),
    .rp (rp.cnt)
  );

  // Counter is held at zero in ST_OFF so a restart begins from 0V
  assign rp.clear = (state_q == ST_OFF);
  assign rp.advance = (state_q == ST_RAMP);

  // Reference arithmetic
  assign final_mv = REF_BASE_MV + MV_W'({7'h00, voltage_code_i} * REF_STEP_MV);
  assign ramp_prod = {12'h000, final_mv} * {12'h000, rp.count};
  assign ramp_mv = ramp_prod[RAMP_SHIFT +: MV_W];

  assign supplies_ok = main_supply_ok_i && driver_supply_ok_i;
  // Inhibit silences every protection, not only the gates
  assign prot_on = ((state_q == ST_RAMP) || (state_q == ST_RUN)) && !inhibit_input_i;
  assign ov_trip = prot_on && sensed_above_ov_i;
  assign uv_armed = prot_on && ((state_q == ST_RUN) || (ramp_mv >= uv_level_q));
  assign uv_trip = uv_armed && sensed_below_uv_i && (uv_cnt_q == (UV_HOLD_CYCLES - 2'h1));

  // Consecutive under-voltage samples; one sample alone is blanked
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      uv_cnt_q <= 2'h0;
    else if (uv_armed && sensed_below_uv_i && uv_cnt_q != UV_HOLD_CYCLES)
      uv_cnt_q <= uv_cnt_q + 2'h1;
    else if (!(uv_armed && sensed_below_uv_i))
      uv_cnt_q <= 2'h0;
  end

  // Sequencer
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_OFF:
      begin
        if (supplies_ok && !inhibit_input_i)
          state_d = ST_RAMP;
      end
      ST_RAMP, ST_RUN:
      begin
        if (inhibit_input_i)
          state_d = ST_OFF;
        else if (!supplies_ok)
          state_d = ST_OFF;
        else if (ov_trip)
          state_d = ST_OV_LATCH;
        else if (uv_trip)
          state_d = ST_UV_LATCH;
        else if (state_q == ST_RAMP && rp.done)
          state_d = ST_RUN;
      end
      ST_UV_LATCH, ST_OV_LATCH:
      begin
        // Only a main supply drop releases a latched fault
        if (!main_supply_ok_i)
          state_d = ST_OFF;
      end
      default:
        state_d = ST_OFF;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_q <= ST_OFF;
    else
      state_q <= state_d;
  end

  // References to the analog comparators
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      loop_ref_q <= 12'h000;
      ov_ref_q <= 12'h000;
    end
    else
    begin
      loop_ref_q <= (state_q == ST_RUN) ? final_mv : ramp_mv;
      ov_ref_q <= final_mv;
    end
  end

  assign loop_ref_mv_o = loop_ref_q;
  assign ov_ref_mv_o = ov_ref_q;

  // Gate drive
  // Next state, so gates drop on the same edge as the fault rises
  assign run_gate = ((state_d == ST_RAMP) || (state_d == ST_RUN)) && !inhibit_input_i;
  assign crowbar = (state_d == ST_OV_LATCH) && !inhibit_input_i;

  phase_gate_driver u_gates (
    .clk_sys_i (clk_sys_i),
    .rst_n_i (rst_n_i),
    .run_i (run_gate),
    .crowbar_i (crowbar),
    .over_limit_i (phase_over_limit_i),
    .pwm_i (pwm_demand_i),
    .high_o (high_side_en_o),
    .low_o (low_side_en_o),
    .ocp_rise_o (ocp_rise)
  );

  // Indicators
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      fault_q <= 1'b0;
      supply_ok_q <= 1'b0;
    end
    else
    begin
      fault_q <= (state_d == ST_UV_LATCH) || (state_d == ST_OV_LATCH);
      // Window only counts once the ramp has finished
      supply_ok_q <= (state_d == ST_RUN) && sensed_in_window_i && !inhibit_input_i;
    end
  end

  assign fault_indicator_o = fault_q;
  assign supply_ok_output_o = supply_ok_q;

  // Interrupt events
  always_comb
  begin
    irq_event = 5'h00;
    irq_event[IRQ_UV] = (state_d == ST_UV_LATCH) && (state_q != ST_UV_LATCH);
    irq_event[IRQ_OV] = (state_d == ST_OV_LATCH) && (state_q != ST_OV_LATCH);
    irq_event[IRQ_OCP] = ocp_rise;
    irq_event[IRQ_RAMP_DONE] = (state_q == ST_RAMP) && (state_d == ST_RUN);
    irq_event[IRQ_SUPPLY] = ((state_q == ST_RAMP) || (state_q == ST_RUN)) && !supplies_ok;
  end

  // APB phases
  assign setup_ph = psel_i && !penable_i;
  assign access_ph = psel_i && penable_i;
  assign wr_en = access_ph && pwrite_i && rd_hit;
  assign irq_clear = (wr_en && paddr_i == OFS_IRQ_STAT) ? pwdata_i[IRQ_W-1:0] : 5'h00;

  // Sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      irq_stat_q <= 5'h00;
    else
      irq_stat_q <= (irq_stat_q & ~irq_clear) | irq_event;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      irq_mask_q <= IRQ_MASK_RESET;
    else if (wr_en && paddr_i == OFS_IRQ_MASK)
      irq_mask_q <= pwdata_i[IRQ_W-1:0];
  end

  // Software may move the under-voltage enable level; default is 0.6V
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      uv_level_q <= UV_ENABLE_MV;
    else if (wr_en && paddr_i == OFS_UV_LEVEL)
      uv_level_q <= pwdata_i[MV_W-1:0];
  end

  assign irq_o = |(irq_stat_q & irq_mask_q);

  // Read decode
  always_comb
  begin
    rd_value = 32'h0000_0000;
    rd_hit = 1'b1;
    if (paddr_i == OFS_STATUS)
    begin
      rd_value[ST_RAMP_DONE_BIT] = rp.done;
      rd_value[ST_FAULT_BIT] = fault_q;
      rd_value[ST_SUPPLY_OK_BIT] = supply_ok_q;
      rd_value[ST_IRQ_BIT] = irq_o;
      rd_value[ST_STATE_LSB +: 3] = 3'(state_q);
    end
    else if (paddr_i == OFS_RAMP)
    begin
      rd_value[RAMP_W-1:0] = rp.count;
      rd_value[RAMP_MV_LSB +: MV_W] = ramp_mv;
    end
    else if (paddr_i == OFS_UV_LEVEL)
      rd_value[MV_W-1:0] = uv_level_q;
    else if (paddr_i == OFS_IRQ_STAT)
      rd_value[IRQ_W-1:0] = irq_stat_q;
    else if (paddr_i == OFS_IRQ_MASK)
      rd_value[IRQ_W-1:0] = irq_mask_q;
    else
      rd_hit = 1'b0;
  end

  // Read data captured in setup so it stands from a flop in the access phase
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      prdata_q <= 32'h0000_0000;
    else if (setup_ph)
      prdata_q <= rd_value;
  end

  assign prdata_o = prdata_q;
  assign pready_o = 1'b1;
  assign pslverr_o = access_ph && !rd_hit;
endmodule : softstart_fault_supervisor

// >>> supervisor_monitor.sv
// Port checker for the soft-start supervisor
`timescale 1ns/10ps
module supervisor_monitor
  import supervisor_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic main_supply_ok_i,
  input wire logic driver_supply_ok_i,
  input wire logic inhibit_input_i,
  input wire logic sensed_below_uv_i,
  input wire logic sensed_above_ov_i,
  input wire logic sensed_in_window_i,
  input wire logic [PHASES-1:0] phase_over_limit_i,
  input wire logic [PHASES-1:0] pwm_demand_i,
  input wire logic [PHASES-1:0] high_side_en_o,
  input wire logic [PHASES-1:0] low_side_en_o,
  input wire logic fault_indicator_o,
  input wire logic supply_ok_output_o
);
  logic [11:0] up_q;
  // Cycles with start conditions held; saturates so it never wraps
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
    if (!rst_n_i)
      up_q <= 12'h000;
    else if (!(main_supply_ok_i && driver_supply_ok_i && !inhibit_input_i))
      up_q <= 12'h000;
    else if (up_q != 12'hFFF)
      up_q <= up_q + 12'h001;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  a_no_overlap: assert property ((high_side_en_o & low_side_en_o) == '0)
    else $error("high and low side on together");
  a_ramp_length: assert property (supply_ok_output_o |-> up_q >= 12'h802)
    else $error("supply ok before ramp end");
  a_window_gate: assert property (supply_ok_output_o |-> $past(sensed_in_window_i) && !$past(inhibit_input_i))
    else $error("supply ok outside window");
  a_inhibit_off: assert property (inhibit_input_i |=> high_side_en_o == '0 && low_side_en_o == '0)
    else $error("gates on under inhibit");
  a_supply_loss: assert property (!(main_supply_ok_i && driver_supply_ok_i) |=> high_side_en_o == '0 && !supply_ok_output_o)
    else $error("running without supplies");
  a_ocp_skip: assert property ((high_side_en_o & $past(phase_over_limit_i)) == '0)
    else $error("high side on in overcurrent");
  a_loop_demand: assert property ((high_side_en_o & ~$past(pwm_demand_i)) == '0)
    else $error("high side without demand");
  a_fault_cause: assert property ($rose(fault_indicator_o) |-> $past(sensed_above_ov_i) || ($past(sensed_below_uv_i) && $past(sensed_below_uv_i, 2)))
    else $error("fault without cause");
  a_fault_hold: assert property ($fell(fault_indicator_o) |-> !$past(main_supply_ok_i))
    else $error("fault cleared without power cycle");
  a_fault_gates: assert property (fault_indicator_o |-> high_side_en_o == '0)
    else $error("high side on while faulted");
endmodule : supervisor_monitor
bind softstart_fault_supervisor supervisor_monitor u_mon (
  .clk_sys_i (clk_sys_i),
  .rst_n_i (rst_n_i),
  .main_supply_ok_i (main_supply_ok_i),
  .driver_supply_ok_i (driver_supply_ok_i),
  .inhibit_input_i (inhibit_input_i),
  .sensed_below_uv_i (sensed_below_uv_i),
  .sensed_above_ov_i (sensed_above_ov_i),
  .sensed_in_window_i (sensed_in_window_i),
  .phase_over_limit_i (phase_over_limit_i),
  .pwm_demand_i (pwm_demand_i),
  .high_side_en_o (high_side_en_o),
  .low_side_en_o (low_side_en_o),
  .fault_indicator_o (fault_indicator_o),
  .supply_ok_output_o (supply_ok_output_o)
);

// >>> analog_front_model.sv
// Behavioural comparators and current sensing in front of the supervisor
`timescale 1ns/10ps
module analog_front_model
  import supervisor_pkg::*;
#(
  parameter int OV_PCT = 130
)
(
  input wire logic [MV_W-1:0] loop_ref_i,
  input wire logic [MV_W-1:0] final_ref_i,
  input wire logic [MV_W-1:0] vout_mv_i,
  input wire logic [15:0] info_ua_i,
  output logic below_uv_o,
  output logic above_ov_o,
  output logic in_window_o,
  output logic [PHASES-1:0] over_limit_o
);
  // Both sides scaled by 100 to keep integer ratios exact
  assign below_uv_o = 100 * vout_mv_i < 60 * loop_ref_i;
  assign above_ov_o = 100 * vout_mv_i >= OV_PCT * final_ref_i;
  assign in_window_o = 100 * vout_mv_i >= 88 * final_ref_i && 100 * vout_mv_i <= 112 * final_ref_i;
  assign over_limit_o[0] = info_ua_i[7:0] > 8'h23;
  assign over_limit_o[1] = info_ua_i[15:8] > 8'h23;
endmodule : analog_front_model

// >>> tb.sv
// Self-checking bench for the soft-start supervisor
`timescale 1ns/10ps
module tb;
  import supervisor_pkg::*;
  typedef struct packed {logic [1:0] k; logic [31:0] m; logic [31:0] e;} note_t;
  logic clk_sys_i, rst_n_i, psel, pen, pwr, pready, pslverr, main_ok, drv_ok, inh, uv, ov, win, fault, pok, irq, trk, err_v;
  logic [7:0] paddr, lf;
  logic [31:0] pwdata, prdata, rd_v, obs;
  logic [4:0] code;
  logic [1:0] olim, pwm, hi, lo;
  logic [11:0] lref, oref, vfix, vout, fin;
  logic [15:0] info;
  int error_cnt, compares;
  note_t nq[$];
  note_t cur;
  assign fin = REF_BASE_MV + REF_STEP_MV * {7'h00, code};
  softstart_fault_supervisor DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .main_supply_ok_i(main_ok), .driver_supply_ok_i(drv_ok), .inhibit_input_i(inh), .voltage_code_i(code),
    .sensed_below_uv_i(uv), .sensed_above_ov_i(ov), .sensed_in_window_i(win), .phase_over_limit_i(olim),
    .pwm_demand_i(pwm), .loop_ref_mv_o(lref), .ov_ref_mv_o(oref), .high_side_en_o(hi), .low_side_en_o(lo),
    .fault_indicator_o(fault), .supply_ok_output_o(pok), .irq_o(irq));
  analog_front_model PM (.loop_ref_i(lref), .final_ref_i(oref), .vout_mv_i(vout), .info_ua_i(info),
    .below_uv_o(uv), .above_ov_o(ov), .in_window_o(win), .over_limit_o(olim));
  always @(posedge clk_sys_i)
    vout <= trk ? lref : vfix;
  initial
  begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : cyc
  task automatic note(input logic [1:0] k, input logic [31:0] m, input logic [31:0] e);
    nq.push_back('{k, m, e});
  endtask : note
  task automatic pchk(input logic [31:0] m, input logic [31:0] e);
    note(2'h0, m, e);
  endtask : pchk
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e, input logic ee);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    pen <= 1'b1;
    @(posedge clk_sys_i);
    while (pready !== 1'b1) @(posedge clk_sys_i);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (!w) note(2'h1, 32'hFFFFFFFF, e);
    note(2'h2, 32'h00000001, {31'h0, ee});
    @(posedge clk_sys_i);
  endtask : apb
  // Random demand; expected gates derived from demand and overcurrent
  task automatic walk();
    repeat (6)
    begin
      lf = lfsr(lf);
      pwm <= lf[1:0];
      cyc(1);
      pchk(32'hF, {28'h0, pwm & ~olim, ~pwm | olim});
    end
  endtask : walk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  always @(negedge clk_sys_i)
    while (nq.size() > 0)
    begin
      cur = nq.pop_front();
      obs = cur.k == 2'h0 ? {13'h0, lref, irq, fault, pok, hi, lo} : cur.k == 2'h1 ? rd_v :
        cur.k == 2'h2 ? {31'h0, err_v} : {20'h0, oref};
      check(obs & cur.m, cur.e);
    end
  initial
  begin
    #(100 * 20000);
    error_cnt++;
    report_and_stop();
  end
  initial
  begin
    {psel, pen, pwr, main_ok, drv_ok, inh, trk, rst_n_i} = '0;
    {paddr, pwdata, code, pwm, vfix, info} = '0;
    lf = 8'h4F;
    cyc(8);
    rst_n_i <= 1'b1;
    cyc(1);
    pchk(32'h7FFFF, 32'h0);
    apb(1'b0, OFS_UV_LEVEL, 32'h0, 32'h258, 1'b0);
    apb(1'b0, OFS_IRQ_MASK, 32'h0, 32'h0, 1'b0);
    apb(1'b0, 8'h14, 32'h0, 32'h0, 1'b1);
    main_ok <= 1'b1;
    cyc(20);
    apb(1'b0, OFS_STATUS, 32'h0, 32'h0, 1'b0);
    apb(1'b1, OFS_IRQ_MASK, 32'h1F, 32'h0, 1'b0);
    lf = lfsr(lf);
    code <= lf[4:0];
    trk <= 1'b1;
    drv_ok <= 1'b1;
    cyc(2);
    walk();
    cyc(2028);
    pchk(32'h10, 32'h0);
    cyc(13);
    pchk(32'h10, 32'h0);
    cyc(1);
    pchk(32'h10, 32'h10);
    cyc(6);
    pchk(32'h7FF80, {13'h0, fin, 7'h0});
    note(2'h3, 32'hFFF, {20'h0, fin});
    apb(1'b0, OFS_STATUS, 32'h0, 32'h2D, 1'b0);
    apb(1'b0, OFS_RAMP, 32'h0, {4'h0, fin, 4'h0, RAMP_FULL}, 1'b0);
    apb(1'b0, OFS_IRQ_STAT, 32'h0, 32'h08, 1'b0);
    apb(1'b1, OFS_IRQ_STAT, 32'h08, 32'h0, 1'b0);
    pchk(32'h40, 32'h0);
    trk <= 1'b0;
    vfix <= fin + fin / 12'h005;
    cyc(3);
    pchk(32'h10, 32'h0);
    vfix <= fin;
    cyc(3);
    pchk(32'h10, 32'h10);
    info <= 16'h0028;
    walk();
    info <= 16'h0000;
    walk();
    apb(1'b0, OFS_IRQ_STAT, 32'h0, 32'h04, 1'b0);
    drv_ok <= 1'b0;
    cyc(2);
    pchk(32'h1C, 32'h0);
    apb(1'b0, OFS_IRQ_STAT, 32'h0, 32'h14, 1'b0);
    apb(1'b1, OFS_IRQ_STAT, 32'h1F, 32'h0, 1'b0);
    trk <= 1'b1;
    drv_ok <= 1'b1;
    cyc(2060);
    trk <= 1'b0;
    vfix <= 12'h000;
    cyc(2);
    pchk(32'h20, 32'h0);
    cyc(1);
    pchk(32'h20, 32'h20);
    vfix <= fin;
    cyc(3);
    pchk(32'h6F, 32'h60);
    main_ok <= 1'b0;
    vfix <= 12'h000;
    cyc(2);
    pchk(32'h20, 32'h0);
    main_ok <= 1'b1;
    cyc(100);
    pchk(32'h20, 32'h0);
    vfix <= fin + fin;
    cyc(3);
    pchk(32'h2F, 32'h23);
    inh <= 1'b1;
    cyc(2);
    pchk(32'h2F, 32'h20);
    inh <= 1'b0;
    cyc(2);
    pchk(32'h2F, 32'h23);
    cyc(2);
    report_and_stop();
  end
endmodule : tb
